// >>> rtl/adc_seq_pkg.sv
package adc_seq_pkg;

    // ==========================================================
    // register indices (byte address is four times the index)
    localparam logic [9:0] IDX_CONTROL_ONE  = 10'h0b4;
    localparam logic [9:0] IDX_SEQ_CONFIG   = 10'h0b5;
    localparam logic [9:0] IDX_EXTRA_CONFIG = 10'h0b6;
    localparam logic [9:0] IDX_PIN_MASK     = 10'h0b7;
    localparam logic [9:0] IDX_RESULT_LOW   = 10'h0ba;
    localparam logic [9:0] IDX_RESULT_HIGH  = 10'h0bb;

    // ==========================================================
    // field positions
    localparam int CTRL_DONE_BIT = 7;
    localparam int CTRL_GO_BIT   = 6;
    localparam int CTRL_TRIG_LSB = 4;
    localparam int CFG_REF_LSB   = 6;
    localparam int CFG_DEC_LSB   = 4;
    localparam int RES_LOW_LSB   = 4;

    // ==========================================================
    // reset values
    localparam logic [7:0] PIN_MASK_RESET = 8'h00;
    localparam logic [1:0] TRIG_RESET     = 2'h3;
    localparam logic [7:0] CFG_RESET      = 8'h00;

    // ==========================================================
    // trigger sources and channel code ranges
    localparam logic [1:0] TRIG_PIN   = 2'h0;
    localparam logic [1:0] TRIG_CHAIN = 2'h1;
    localparam logic [1:0] TRIG_TIMER = 2'h2;
    localparam logic [1:0] TRIG_GO    = 2'h3;
    localparam logic [3:0] CODE_FIRST_DIFF = 4'h8;
    localparam logic [3:0] CODE_FIRST_INT  = 4'hc;

    // ==========================================================
    // timing in adc clock periods, clock divider in pclk cycles, resolutions in bits
    localparam logic [2:0] ADC_CLK_DIV    = 3'h6;
    localparam logic [9:0] SETTLE_PERIODS = 10'h010;
    localparam logic [3:0][9:0] DECIM_PERIODS = {10'h200, 10'h100, 10'h080, 10'h040};
    localparam logic [3:0][3:0] RESOLUTION    = {4'hc, 4'ha, 4'h9, 4'h7};
    localparam logic [3:0] FULL_WIDTH = 4'hc;

    typedef enum logic [1:0] {S_IDLE, S_PICK, S_CONV} seq_state_e;

endpackage : adc_seq_pkg

// >>> rtl/adc_conversion_sequencer.sv
// How it works
// - pin converts only when mask bit set
// - differential pairs are 0-1, 2-3, 4-5, 6-7
// - skip disabled inputs; pairs need both pins
// - code picks single, pair or internal source
// - single-ended codes walk input 0 upward
// - differential codes walk pair 0-1 upward
// - internal codes convert exactly once
// - done flag set on finish, cleared reading high
// - go bit starts when selected, cleared at end
// - trigger select picks one of four starts
// - extra config write queues one conversion
// - extra conversion uses its own config
// - no pins enabled still updates code; a sequence also sets flag
// - decimation rate sets result resolution
// - select 00 starts on trigger pin edge
// - interrupt only after extra conversion
// - dma pulse per sequence sample, not extra
// - conversion lasts decimation plus 16 periods
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module adc_conversion_sequencer (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        external_trigger_pin,
    input  wire logic        timer_compare_event,
    input  wire logic [11:0] core_result,
    output logic      [7:0]  analog_input_pins,
    output logic      [3:0]  core_channel,
    output logic      [1:0]  core_reference,
    output logic      [1:0]  core_decimation,
    output logic             core_converting,
    output logic             adc_clock_pulse,
    output logic             dma_trigger,
    output logic             irq
);

    // ==========================================================
    // state
    typedef struct packed {
        adc_seq_pkg::seq_state_e state;
        logic [7:0]  mask;
        logic        go;
        logic [1:0]  trig_sel;
        logic [7:0]  seq_cfg;
        logic [7:0]  extra_cfg;
        logic        extra_pending;
        logic        done_flag;
        logic [11:0] result;
        logic        is_extra;
        logic [3:0]  cur_ch;
        logic [3:0]  last_ch;
        logic [1:0]  run_ref;
        logic [1:0]  run_dec;
        logic        any_conv;
        logic        converting;
        logic [2:0]  div_cnt;
        logic [9:0]  conv_cnt;
        logic        pin_sync1;
        logic        pin_sync2;
        logic        pin_prev;
        logic        seq_end_pulse;
        logic        dma_pulse;
        logic        irq_pulse;
        logic        clk_pulse;
        logic [31:0] prdata;
    } seq_s;

    seq_s        state_reg;
    seq_s        state_next;
    logic [9:0]  idx;
    logic        hit;
    logic        setup;
    logic        wr_done;
    logic        rd_done;
    logic [31:0] rd_val;
    logic        tick;
    logic        trigger;
    logic        start_req;
    logic        pin_ok;
    logic        advance;
    logic        finish;
    logic [9:0]  target;
    logic [3:0]  res_bits;
    logic [11:0] res_mask;
    logic [3:0]  seq_code;

    // ==========================================================
    // bus decode
    assign idx     = paddr[11:2];
    assign hit     = (paddr[1:0] == 2'h0) &&
                     (idx == adc_seq_pkg::IDX_CONTROL_ONE || idx == adc_seq_pkg::IDX_SEQ_CONFIG ||
                      idx == adc_seq_pkg::IDX_EXTRA_CONFIG || idx == adc_seq_pkg::IDX_PIN_MASK ||
                      idx == adc_seq_pkg::IDX_RESULT_LOW || idx == adc_seq_pkg::IDX_RESULT_HIGH);
    assign setup   = psel && !penable;
    assign wr_done = psel && penable && pwrite && hit;
    assign rd_done = psel && penable && !pwrite && hit;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata  = state_reg.prdata;

    always_comb begin
        rd_val = 32'h0;
        if (paddr[1:0] == 2'h0) begin
            case (idx)
                adc_seq_pkg::IDX_CONTROL_ONE:  rd_val[7:0] = {state_reg.done_flag, state_reg.go,
                                                              state_reg.trig_sel, 4'h0};
                adc_seq_pkg::IDX_SEQ_CONFIG:   rd_val[7:0] = state_reg.seq_cfg;
                adc_seq_pkg::IDX_EXTRA_CONFIG: rd_val[7:0] = state_reg.extra_cfg;
                adc_seq_pkg::IDX_PIN_MASK:     rd_val[7:0] = state_reg.mask;
                adc_seq_pkg::IDX_RESULT_LOW:   rd_val[7:0] = {state_reg.result[3:0], 4'h0};
                adc_seq_pkg::IDX_RESULT_HIGH:  rd_val[7:0] = state_reg.result[11:4];
                default:                       rd_val = 32'h0;
            endcase
        end
    end

    // ==========================================================
    // sequencing helpers
    assign seq_code = state_reg.seq_cfg[3:0];
    assign tick     = (state_reg.div_cnt == adc_seq_pkg::ADC_CLK_DIV - 3'h1);
    assign target   = adc_seq_pkg::DECIM_PERIODS[state_reg.run_dec] +
                      adc_seq_pkg::SETTLE_PERIODS;
    assign res_bits = adc_seq_pkg::RESOLUTION[state_reg.run_dec];
    assign res_mask = 12'hfff << (adc_seq_pkg::FULL_WIDTH - res_bits);
    assign finish   = (state_reg.state == adc_seq_pkg::S_CONV) && tick &&
                      (state_reg.conv_cnt == target - 10'h001);

    always_comb begin
        case (state_reg.trig_sel)
            adc_seq_pkg::TRIG_PIN:   trigger = state_reg.pin_sync2 && !state_reg.pin_prev;
            adc_seq_pkg::TRIG_CHAIN: trigger = state_reg.seq_end_pulse;
            adc_seq_pkg::TRIG_TIMER: trigger = timer_compare_event;
            default:                 trigger = state_reg.go;
        endcase
    end
    assign start_req = (state_reg.state == adc_seq_pkg::S_IDLE) && !state_reg.extra_pending &&
                       trigger;

    always_comb begin
        if (state_reg.cur_ch < adc_seq_pkg::CODE_FIRST_DIFF) begin
            pin_ok = state_reg.mask[state_reg.cur_ch[2:0]];
        end else if (state_reg.cur_ch < adc_seq_pkg::CODE_FIRST_INT) begin
            pin_ok = state_reg.mask[{state_reg.cur_ch[1:0], 1'b0}] &&
                     state_reg.mask[{state_reg.cur_ch[1:0], 1'b1}];
        end else begin
            pin_ok = 1'b1;
        end
    end

    // ==========================================================
    // next state
    always_comb begin
        state_next = state_reg;
        advance = 1'b0;
        state_next.dma_pulse = 1'b0;
        state_next.irq_pulse = 1'b0;
        state_next.seq_end_pulse = 1'b0;
        state_next.pin_sync1 = external_trigger_pin;
        state_next.pin_sync2 = state_reg.pin_sync1;
        state_next.pin_prev = state_reg.pin_sync2;
        state_next.div_cnt = tick ? 3'h0 : state_reg.div_cnt + 3'h1;
        state_next.clk_pulse = tick;
        if (setup) begin
            state_next.prdata = rd_val;
        end
        if (rd_done && idx == adc_seq_pkg::IDX_RESULT_HIGH) begin
            state_next.done_flag = 1'b0;
        end
        case (state_reg.state)
            adc_seq_pkg::S_IDLE: begin
                if (state_reg.extra_pending) begin
                    state_next.extra_pending = 1'b0;
                    state_next.is_extra = 1'b1;
                    state_next.cur_ch = state_reg.extra_cfg[3:0];
                    state_next.run_ref = state_reg.extra_cfg[adc_seq_pkg::CFG_REF_LSB +: 2];
                    state_next.run_dec = state_reg.extra_cfg[adc_seq_pkg::CFG_DEC_LSB +: 2];
                    state_next.state = adc_seq_pkg::S_PICK;
                end else if (start_req) begin
                    state_next.is_extra = 1'b0;
                    state_next.any_conv = 1'b0;
                    state_next.last_ch = seq_code;
                    state_next.cur_ch = adc_seq_pkg::CODE_FIRST_DIFF;
                    if (!seq_code[3]) begin
                        state_next.cur_ch = 4'h0;
                    end else if (seq_code[2]) begin
                        state_next.cur_ch = seq_code;
                    end
                    state_next.run_ref = state_reg.seq_cfg[adc_seq_pkg::CFG_REF_LSB +: 2];
                    state_next.run_dec = state_reg.seq_cfg[adc_seq_pkg::CFG_DEC_LSB +: 2];
                    state_next.state = adc_seq_pkg::S_PICK;
                end
            end
            adc_seq_pkg::S_PICK: begin
                if (pin_ok) begin
                    state_next.converting = 1'b1;
                    state_next.conv_cnt = 10'h000;
                    state_next.state = adc_seq_pkg::S_CONV;
                end else begin
                    advance = 1'b1;
                end
            end
            adc_seq_pkg::S_CONV: begin
                if (finish) begin
                    state_next.converting = 1'b0;
                    state_next.result = core_result & res_mask;
                    state_next.done_flag = 1'b1;
                    state_next.dma_pulse = !state_reg.is_extra;
                    state_next.irq_pulse = state_reg.is_extra;
                    state_next.any_conv = 1'b1;
                    advance = 1'b1;
                end else if (tick) begin
                    state_next.conv_cnt = state_reg.conv_cnt + 10'h001;
                end
            end
            default: begin
                state_next.state = adc_seq_pkg::S_IDLE;
            end
        endcase
        if (advance) begin
            if (state_reg.is_extra) begin
                state_next.seq_cfg[3:0] = state_reg.cur_ch;
                state_next.state = adc_seq_pkg::S_IDLE;
            end else if (state_reg.cur_ch == state_reg.last_ch ||
                         state_reg.cur_ch >= adc_seq_pkg::CODE_FIRST_INT) begin
                state_next.seq_cfg[3:0] = (state_reg.last_ch < adc_seq_pkg::CODE_FIRST_INT) ?
                                          state_reg.last_ch + 4'h1 : state_reg.last_ch;
                state_next.go = 1'b0;
                if (!state_next.any_conv) begin
                    state_next.done_flag = 1'b1;
                end
                state_next.seq_end_pulse = 1'b1;
                state_next.state = adc_seq_pkg::S_IDLE;
            end else begin
                state_next.cur_ch = state_reg.cur_ch + 4'h1;
                state_next.state = adc_seq_pkg::S_PICK;
            end
        end
        if (wr_done) begin
            case (idx)
                adc_seq_pkg::IDX_CONTROL_ONE: begin
                    if (pwdata[adc_seq_pkg::CTRL_GO_BIT]) begin
                        state_next.go = 1'b1;
                    end
                    state_next.trig_sel = pwdata[adc_seq_pkg::CTRL_TRIG_LSB +: 2];
                end
                adc_seq_pkg::IDX_SEQ_CONFIG: begin
                    state_next.seq_cfg = pwdata[7:0];
                end
                adc_seq_pkg::IDX_EXTRA_CONFIG: begin
                    state_next.extra_cfg = pwdata[7:0];
                    state_next.extra_pending = 1'b1;
                end
                adc_seq_pkg::IDX_PIN_MASK: begin
                    state_next.mask = pwdata[7:0];
                end
                default: begin
                    state_next.mask = state_next.mask;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
            state_reg.state <= adc_seq_pkg::S_IDLE;
            state_reg.mask <= adc_seq_pkg::PIN_MASK_RESET;
            state_reg.trig_sel <= adc_seq_pkg::TRIG_RESET;
            state_reg.seq_cfg <= adc_seq_pkg::CFG_RESET;
            state_reg.extra_cfg <= adc_seq_pkg::CFG_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // outputs
    assign analog_input_pins = state_reg.mask;
    assign core_channel      = state_reg.cur_ch;
    assign core_reference    = state_reg.run_ref;
    assign core_decimation   = state_reg.run_dec;
    assign core_converting   = state_reg.converting;
    assign adc_clock_pulse   = state_reg.clk_pulse;
    assign dma_trigger       = state_reg.dma_pulse;
    assign irq               = state_reg.irq_pulse;

    // ==========================================================
    // checks
    int conv_cycles;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_cycles <= 0;
        end else begin
            conv_cycles <= state_reg.converting ? conv_cycles + 1 : 0;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence extra_queued;
        wr_done && idx == adc_seq_pkg::IDX_EXTRA_CONFIG &&
        state_reg.state == adc_seq_pkg::S_IDLE && !start_req;
    endsequence
    sequence extra_running;
        ##[1:2] (state_reg.state == adc_seq_pkg::S_PICK && state_reg.is_extra);
    endsequence

    AST_SINGLE_ENABLED: assert property (
        state_reg.converting && state_reg.cur_ch < 4'h8
        |-> state_reg.mask[state_reg.cur_ch[2:0]])
        else $error("disabled input converted");
    AST_PAIR_ENABLED: assert property (
        state_reg.converting && state_reg.cur_ch[3:2] == 2'h2
        |-> state_reg.mask[{state_reg.cur_ch[1:0], 1'b0}] &&
            state_reg.mask[{state_reg.cur_ch[1:0], 1'b1}])
        else $error("pair converted without both pins");
    AST_DONE_SET: assert property (finish |=> state_reg.done_flag)
        else $error("done flag not set");
    AST_DONE_CLEAR: assert property (
        rd_done && idx == adc_seq_pkg::IDX_RESULT_HIGH && !finish && !advance
        |=> !state_reg.done_flag)
        else $error("done flag not cleared by read");
    AST_GO_START: assert property (
        start_req && state_reg.trig_sel == 2'h3
        |=> state_reg.state == adc_seq_pkg::S_PICK && !state_reg.is_extra)
        else $error("go bit did not start");
    AST_IRQ_EXTRA: assert property (
        irq |-> $past(state_reg.is_extra) && !dma_trigger)
        else $error("interrupt outside extra conversion");
    AST_DMA_SEQ: assert property (
        finish && !state_reg.is_extra |=> dma_trigger && !irq)
        else $error("missing dma trigger");
    AST_CONV_LEN: assert property (
        finish |-> conv_cycles >= (int'(target) - 1) * 6 && conv_cycles < int'(target) * 6)
        else $error("conversion length wrong");
    AST_EXTRA_RUNS: assert property (extra_queued |-> extra_running)
        else $error("extra conversion not started");
    AST_INTERNAL_ONCE: assert property (
        finish && !state_reg.is_extra && state_reg.cur_ch >= 4'hc
        |=> state_reg.state == adc_seq_pkg::S_IDLE)
        else $error("internal source repeated");

endmodule : adc_conversion_sequencer

`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;

    // ==========================================================
    // signals
    localparam logic [9:0] CTL = adc_seq_pkg::IDX_CONTROL_ONE;
    localparam logic [9:0] SEQ = adc_seq_pkg::IDX_SEQ_CONFIG;
    localparam logic [9:0] EXT = adc_seq_pkg::IDX_EXTRA_CONFIG;
    localparam logic [9:0] MSK = adc_seq_pkg::IDX_PIN_MASK;
    localparam logic [9:0] LO  = adc_seq_pkg::IDX_RESULT_LOW;
    localparam logic [9:0] HI  = adc_seq_pkg::IDX_RESULT_HIGH;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        ext_pin, timer_evt, converting, dma, irq, was_conv, adc_tick;
    logic [11:0] paddr, core_val;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  pins;
    logic [3:0]  chan, seen_chan;
    logic [1:0]  ref_o, dec_o, seen_ref, seen_dec;
    int          failures, check_count, dma_n, irq_n, starts, conv_n, cycles, tick_n;

    adc_conversion_sequencer i_adc_conversion_sequencer (
        .pclk                 (pclk),
        .presetn              (presetn),
        .psel                 (psel),
        .penable              (penable),
        .pwrite               (pwrite),
        .paddr                (paddr),
        .pwdata               (pwdata),
        .prdata               (prdata),
        .pready               (pready),
        .pslverr              (pslverr),
        .external_trigger_pin (ext_pin),
        .timer_compare_event  (timer_evt),
        .core_result          (core_val),
        .analog_input_pins    (pins),
        .core_channel         (chan),
        .core_reference       (ref_o),
        .core_decimation      (dec_o),
        .core_converting      (converting),
        .adc_clock_pulse      (adc_tick),
        .dma_trigger          (dma),
        .irq                  (irq)
    );

    // ==========================================================
    // clock, monitor, timeout
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        was_conv <= converting;
        if (dma === 1'b1) dma_n <= dma_n + 1;
        if (irq === 1'b1) irq_n <= irq_n + 1;
        if (adc_tick === 1'b1) tick_n <= tick_n + 1;
        if (converting === 1'b1) begin
            conv_n <= conv_n + 1;
            seen_chan <= chan;
            seen_ref <= ref_o;
            seen_dec <= dec_o;
        end
        if (converting === 1'b1 && was_conv !== 1'b1) starts <= starts + 1;
        if (cycles == 50000) begin
            failures++;
            give_verdict();
        end
    end

    // ==========================================================
    // helpers
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
        apb(1'b1, idx, wd);
    endtask : wr

    task automatic rc(input logic [9:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        check(rd, exp);
    endtask : rc

    task automatic clr();
        @(negedge pclk);
        dma_n = 0;
        irq_n = 0;
        starts = 0;
        conv_n = 0;
        tick_n = 0;
    endtask : clr

    task automatic wait_quiet();
        int q;
        q = 0;
        while (q < 16) begin
            @(posedge pclk);
            q = (converting === 1'b1) ? 0 : q + 1;
        end
    endtask : wait_quiet

    task automatic go_run(input logic [7:0] mask, input logic [7:0] cfg);
        wr(MSK, {24'h0, mask});
        wr(SEQ, {24'h0, cfg});
        apb(1'b0, HI, 32'h0);
        clr();
        wr(CTL, 32'h70);
        wait_quiet();
    endtask : go_run

    // ==========================================================
    // tests
    task automatic t_reset();
        rc(MSK, 32'h00);
        rc(CTL, 32'h30);
        rc(SEQ, 32'h00);
        apb(1'b0, 10'h0b8, 32'h0);
        check({31'h0, err}, 32'h1);
        clr();
        repeat (60) @(posedge pclk);
        @(negedge pclk);
        check(tick_n, 10);
        $display("test reset done");
    endtask : t_reset

    task automatic t_codes();
        for (int i = 0; i < 16; i++) begin
            go_run(8'hff, 8'(i));
            check(dma_n, (i < 8) ? i + 1 : (i < 12) ? i - 7 : 1);
            rc(SEQ, (i < 12) ? i + 1 : i);
            if (i > 11) check({28'h0, seen_chan}, i);
            if (i == 12) check(32'(conv_n >= 474 && conv_n <= 486), 1);
        end
        $display("test codes done");
    endtask : t_codes

    task automatic t_mask();
        go_run(8'h05, 8'h02);
        check(dma_n, 2);
        check(irq_n, 0);
        rc(CTL, 32'hb0);
        rc(LO, 32'h00);
        rc(HI, 32'haa);
        rc(CTL, 32'h30);
        go_run(8'h0b, 8'h09);
        check(dma_n, 1);
        check({24'h0, pins}, 32'h0b);
        go_run(8'h00, 8'h03);
        check(dma_n, 0);
        rc(SEQ, 32'h04);
        rc(CTL, 32'hb0);
        $display("test mask done");
    endtask : t_mask

    task automatic t_extra();
        wr(MSK, 32'hff);
        clr();
        wr(EXT, 32'h95);
        wait_quiet();
        check(irq_n, 1);
        check(dma_n, 0);
        check(starts, 1);
        check({24'h0, seen_ref, seen_dec, seen_chan}, 32'h95);
        rc(SEQ, 32'h05);
        rc(LO, 32'h80);
        rc(HI, 32'hab);
        check(32'(conv_n >= 858 && conv_n <= 870), 1);
        wr(MSK, 32'h03);
        wr(SEQ, 32'h01);
        clr();
        wr(CTL, 32'h70);
        wr(EXT, 32'h0c);
        wait_quiet();
        check(starts, 3);
        check(dma_n, 2);
        check(irq_n, 1);
        rc(SEQ, 32'h0c);
        $display("test extra done");
    endtask : t_extra

    task automatic t_trig();
        wr(SEQ, 32'h01);
        clr();
        wr(CTL, 32'h40);
        repeat (20) @(posedge pclk);
        check(starts, 0);
        ext_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        ext_pin <= 1'b0;
        wait_quiet();
        check(dma_n, 2);
        rc(CTL, 32'h80);
        clr();
        wr(CTL, 32'h20);
        @(posedge pclk);
        timer_evt <= 1'b1;
        @(posedge pclk);
        timer_evt <= 1'b0;
        wait_quiet();
        check(dma_n, 2);
        clr();
        wr(CTL, 32'h70);
        wr(CTL, 32'h10);
        while (starts < 3) @(posedge pclk);
        wr(CTL, 32'h30);
        wait_quiet();
        check(starts, 4);
        $display("test trigger done");
    endtask : t_trig

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict

    // ==========================================================
    // main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        ext_pin = 1'b0;
        timer_evt = 1'b0;
        core_val = 12'habc;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_codes();
        t_mask();
        t_extra();
        t_trig();
        give_verdict();
    end

endmodule : tb_top

`default_nettype wire
